// ===== src/snp_packetizer.sv
// Connection control and packetizing decisions for one serial channel
`timescale 1ns/1ps
`default_nettype none
module snp_packetizer
    import snp_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_disconnect_policy,
    input wire logic [7:0] i_buffer_clear_policy,
    input wire logic [7:0] i_packing_control,
    input wire logic [12:0] i_idle_timeout,
    input wire logic [7:0] i_trigger_char_first,
    input wire logic [7:0] i_trigger_char_second,
    input wire logic i_ser_valid,
    input wire logic [7:0] i_ser_byte,
    input wire logic i_line_status,
    input wire logic i_conn_open_out,
    input wire logic i_conn_open_in,
    input wire logic i_password_ok,
    input wire logic i_conn_closed,
    input wire logic i_close_ack,
    input wire logic i_status_tx_req,
    output logic o_net_valid,
    output logic [7:0] o_net_byte,
    output logic o_net_send,
    output logic o_s2n_clear,
    output logic o_n2s_clear,
    output logic o_drop_conn,
    output logic o_force_close,
    output logic o_send_term_type,
    output logic o_telnet_opts_en,
    output logic o_connected,
    output logic o_state_led
);

    snp_conn_state_t state_q;
    logic ms_tick;
    logic frame_end;
    logic line_prev_q;
    logic defer_q;
    logic pending_q;
    logic [MS_W-1:0] gap_ms_q;
    logic [MS_W-1:0] idle_ms_q;
    logic [12:0] idle_s_q;
    logic [MS_W-1:0] close_ms_q;
    logic [MS_W-1:0] led_ms_q;
    logic blink_q;

    logic alt_pack;
    logic immediate;
    logic [MS_W-1:0] interval_ms;
    logic line_fall;
    logic eot_hit;
    logic idle_expire;
    logic drop_req;
    logic accept_in;
    logic ev_open_out;
    logic ev_open_in;
    logic ev_reject;
    logic ev_force;
    logic ev_disc;
    logic is_open;
    logic gap_expired;
    logic send_now;
    logic s2n_clr;

    snp_ms_tick #(
        .CYCLES(MS_CYCLES)
    ) u_tick (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .o_tick(ms_tick)
    );

    snp_trigger_match u_match (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_valid(i_ser_valid),
        .i_byte(i_ser_byte),
        .i_first(i_trigger_char_first),
        .i_second(i_trigger_char_second),
        .i_seq2(alt_pack && i_packing_control[PC_SEQ2]),
        .i_tail(alt_pack ? i_packing_control[PC_TAIL_LSB+:2] : 2'b00),
        .i_clear(s2n_clr),
        .o_frame_end(frame_end)
    );

    // Packing mode selection
    always_comb begin
        alt_pack = i_buffer_clear_policy[BC_ALT_PACK];
        // Standard packing sends on recognition of a trigger
        immediate = !alt_pack || i_packing_control[PC_IMMEDIATE];
        if (alt_pack) begin
            case (i_packing_control[PC_IVL_LSB+:2])
                2'b00: interval_ms = IVL0_MS;
                2'b01: interval_ms = IVL1_MS;
                2'b10: interval_ms = IVL2_MS;
                2'b11: interval_ms = IVL3_MS;
                default: interval_ms = IVL0_MS;
            endcase
        end else begin
            interval_ms = STD_GAP_MS;
        end
    end

    // Drop conditions
    always_comb begin
        is_open = (state_q == CS_OPEN);
        line_fall = i_disconnect_policy[DP_LINE_DROP] && line_prev_q && !i_line_status;
        eot_hit = i_disconnect_policy[DP_EOT] && i_disconnect_policy[DP_TELNET]
            && i_ser_valid && (i_ser_byte == EOT_CHAR);
        idle_expire = (i_idle_timeout != 13'h0000) && (idle_s_q >= i_idle_timeout);
        drop_req = line_fall || eot_hit || idle_expire;
    end

    // Connection events
    // Outgoing open wins when both arrive in one cycle
    always_comb begin
        accept_in = !i_disconnect_policy[DP_PASSWORD] || i_password_ok;
        ev_open_out = (state_q == CS_IDLE) && i_conn_open_out;
        ev_open_in = (state_q == CS_IDLE) && !i_conn_open_out && i_conn_open_in && accept_in;
        ev_reject = (state_q == CS_IDLE) && !i_conn_open_out && i_conn_open_in && !accept_in;
        ev_force = (state_q == CS_CLOSING) && !i_close_ack && !i_conn_closed
            && !i_disconnect_policy[DP_NO_HARD_CLOSE] && ms_tick
            && (close_ms_q >= HARD_CLOSE_MS - 13'h0001);
        ev_disc = (is_open && i_conn_closed)
            || ((state_q == CS_CLOSING) && (i_close_ack || i_conn_closed))
            || ev_force;
        s2n_clr = (ev_open_out && i_buffer_clear_policy[BC_S2N_OUT])
            || (ev_open_in && i_buffer_clear_policy[BC_S2N_IN])
            || (ev_disc && i_buffer_clear_policy[BC_S2N_DISC]);
    end

    // Send decision
    // A clear in the same cycle wins, so stale bytes never leave
    always_comb begin
        gap_expired = pending_q && !i_ser_valid && (gap_ms_q >= interval_ms);
        send_now = is_open && !s2n_clr && (
            (i_ser_valid && frame_end && immediate)
            || (defer_q && !i_ser_valid)
            || gap_expired
            || i_status_tx_req);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_q <= CS_IDLE;
        end else begin
            case (state_q)
                CS_IDLE: begin
                    if (ev_open_out || ev_open_in) begin
                        state_q <= CS_OPEN;
                    end
                end
                CS_OPEN: begin
                    // Remote close beats a local drop request
                    if (i_conn_closed) begin
                        state_q <= CS_IDLE;
                    end else if (drop_req) begin
                        state_q <= CS_CLOSING;
                    end
                end
                CS_CLOSING: begin
                    if (ev_disc) begin
                        state_q <= CS_IDLE;
                    end
                end
                default: state_q <= CS_IDLE;
            endcase
        end
    end

    // Waiting for the remote close acknowledge
    // Saturates so a long wait cannot wrap back into range
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || (state_q != CS_CLOSING)) begin
            close_ms_q <= '0;
        end else if (ms_tick && (close_ms_q != HARD_CLOSE_MS)) begin
            close_ms_q <= close_ms_q + 13'h0001;
        end
    end

    // Reset value low so a line already low at release is no edge
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            line_prev_q <= 1'b0;
        end else begin
            line_prev_q <= i_line_status;
        end
    end

    // Idle timeout counted in whole seconds
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !is_open || i_ser_valid) begin
            idle_ms_q <= '0;
            idle_s_q <= '0;
        end else if (ms_tick) begin
            if (idle_ms_q == MS_PER_S - 13'h0001) begin
                idle_ms_q <= '0;
                if (idle_s_q != IDLE_MAX_S) begin
                    idle_s_q <= idle_s_q + 13'h0001;
                end
            end else begin
                idle_ms_q <= idle_ms_q + 13'h0001;
            end
        end
    end

    // Gap since last byte, saturates at the longest interval
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || i_ser_valid) begin
            gap_ms_q <= '0;
        end else if (ms_tick && (gap_ms_q != IVL3_MS)) begin
            gap_ms_q <= gap_ms_q + 13'h0001;
        end
    end

    // Bytes waiting for a send
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || s2n_clr) begin
            pending_q <= 1'b0;
        end else if (i_ser_valid) begin
            pending_q <= !(send_now && frame_end && immediate);
        end else if (send_now) begin
            pending_q <= 1'b0;
        end
    end

    // Deferred send keeps back-to-back bytes in the same segment
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || s2n_clr || !is_open) begin
            defer_q <= 1'b0;
        end else if (i_ser_valid && frame_end && !immediate) begin
            defer_q <= 1'b1;
        end else if (send_now) begin
            defer_q <= 1'b0;
        end
    end

    // Serial byte stream towards the network side
    // Bytes pass even while idle and are dropped only by a clear; the send strobe also needs the open state
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_net_valid <= 1'b0;
            o_net_byte <= 8'h00;
            o_net_send <= 1'b0;
        end else begin
            o_net_valid <= i_ser_valid && !s2n_clr;
            o_net_byte <= i_ser_byte;
            o_net_send <= send_now;
        end
    end

    // Buffer clear strobes
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_s2n_clear <= 1'b0;
            o_n2s_clear <= 1'b0;
        end else begin
            o_s2n_clear <= s2n_clr;
            o_n2s_clear <= (ev_open_out && i_buffer_clear_policy[BC_N2S_OUT])
                || (ev_open_in && i_buffer_clear_policy[BC_N2S_IN])
                || (ev_disc && i_buffer_clear_policy[BC_N2S_DISC]);
        end
    end

    // Connection control strobes
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_drop_conn <= 1'b0;
            o_force_close <= 1'b0;
            o_send_term_type <= 1'b0;
        end else begin
            o_drop_conn <= (is_open && !i_conn_closed && drop_req) || ev_reject;
            o_force_close <= ev_force;
            o_send_term_type <= ev_open_out && i_disconnect_policy[DP_TELNET];
        end
    end

    // Option levels
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_telnet_opts_en <= 1'b0;
            o_connected <= 1'b0;
        end else begin
            o_telnet_opts_en <= i_disconnect_policy[DP_TELNET];
            o_connected <= (state_q != CS_IDLE);
        end
    end

    // Blink phase for the state indicator
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            led_ms_q <= '0;
            blink_q <= 1'b0;
        end else if (ms_tick) begin
            if (led_ms_q == LED_HALF_MS - 13'h0001) begin
                led_ms_q <= '0;
                blink_q <= !blink_q;
            end else begin
                led_ms_q <= led_ms_q + 13'h0001;
            end
        end
    end

    // Steady on when idle, blinking while connected unless held off
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_state_led <= 1'b1;
        end else if (state_q == CS_IDLE) begin
            o_state_led <= 1'b1;
        end else if (i_disconnect_policy[DP_LED_OFF]) begin
            o_state_led <= 1'b0;
        end else begin
            o_state_led <= blink_q;
        end
    end

endmodule
`default_nettype wire

// ===== src/snp_pkg.sv
// Shared constants and types for the serial network packetizer
package snp_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int MS_W = 13;
    localparam logic [MS_W-1:0] MS_PER_S = 13'h3e8;

    // Disconnect policy bit positions
    localparam int DP_LINE_DROP = 7;
    localparam int DP_TELNET = 6;
    localparam int DP_EOT = 5;
    localparam int DP_PASSWORD = 4;
    localparam int DP_NO_HARD_CLOSE = 3;
    localparam int DP_LED_OFF = 0;

    // Buffer clear policy bit positions
    localparam int BC_N2S_OUT = 0;
    localparam int BC_N2S_IN = 1;
    localparam int BC_N2S_DISC = 2;
    localparam int BC_S2N_OUT = 4;
    localparam int BC_S2N_IN = 5;
    localparam int BC_S2N_DISC = 6;
    localparam int BC_ALT_PACK = 7;

    // Packing control field positions
    localparam int PC_IVL_LSB = 0;
    localparam int PC_TAIL_LSB = 2;
    localparam int PC_SEQ2 = 4;
    localparam int PC_IMMEDIATE = 5;

    // Times in milliseconds
    localparam logic [MS_W-1:0] IVL0_MS = 13'h00c;
    localparam logic [MS_W-1:0] IVL1_MS = 13'h034;
    localparam logic [MS_W-1:0] IVL2_MS = 13'h0fa;
    localparam logic [MS_W-1:0] IVL3_MS = 13'h1388;
    localparam logic [MS_W-1:0] STD_GAP_MS = 13'h001;
    localparam logic [MS_W-1:0] HARD_CLOSE_MS = 13'h3e8;
    localparam logic [MS_W-1:0] LED_HALF_MS = 13'h1f4;

    // Characters and limits
    localparam logic [7:0] EOT_CHAR = 8'h04;
    localparam logic [7:0] TRIGGER_OFF = 8'h00;
    localparam logic [12:0] IDLE_MAX_S = 13'h176f;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_OPEN = 2'b01,
        CS_CLOSING = 2'b10
    } snp_conn_state_t;

endpackage

// ===== src/snp_ms_tick.sv
// Millisecond tick prescaler
`timescale 1ns/1ps
`default_nettype none
module snp_ms_tick #(
    parameter int CYCLES = 100000
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    output logic o_tick
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cnt_q <= '0;
            o_tick <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== src/snp_trigger_match.sv
// Trigger character matcher with trailing character count
`timescale 1ns/1ps
`default_nettype none
module snp_trigger_match (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_valid,
    input wire logic [7:0] i_byte,
    input wire logic [7:0] i_first,
    input wire logic [7:0] i_second,
    input wire logic i_seq2,
    input wire logic [1:0] i_tail,
    input wire logic i_clear,
    output logic o_frame_end
);
    logic armed_q;
    logic tail_act_q;
    logic [1:0] tail_q;
    logic enabled;
    logic hit;
    logic [1:0] tail_n;

    always_comb begin
        enabled = (i_first != snp_pkg::TRIGGER_OFF);
        if (i_seq2) begin
            hit = enabled && armed_q && (i_byte == i_second);
        end else begin
            hit = enabled && ((i_byte == i_first) || ((i_second != snp_pkg::TRIGGER_OFF) && (i_byte == i_second)));
        end
        // Code 11 has no defined count, treated as none
        tail_n = (i_tail == 2'b11) ? 2'b00 : i_tail;
        o_frame_end = i_valid && (tail_act_q ? (tail_q == 2'b01) : (hit && (tail_n == 2'b00)));
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || i_clear) begin
            armed_q <= 1'b0;
            tail_act_q <= 1'b0;
            tail_q <= 2'b00;
        end else if (i_valid) begin
            armed_q <= enabled && i_seq2 && (i_byte == i_first);
            if (tail_act_q) begin
                tail_q <= tail_q - 2'b01;
                tail_act_q <= (tail_q != 2'b01);
            end else if (hit && (tail_n != 2'b00)) begin
                tail_act_q <= 1'b1;
                tail_q <= tail_n;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/snp_packetizer_asserts.sv
// Port-level checks for the serial network packetizer
`timescale 1ns/1ps
`default_nettype none
module snp_packetizer_asserts
    import snp_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_disconnect_policy,
    input wire logic [7:0] i_buffer_clear_policy,
    input wire logic [7:0] i_packing_control,
    input wire logic [7:0] i_trigger_char_first,
    input wire logic i_ser_valid,
    input wire logic [7:0] i_ser_byte,
    input wire logic i_line_status,
    input wire logic i_conn_open_out,
    input wire logic i_conn_open_in,
    input wire logic i_password_ok,
    input wire logic i_conn_closed,
    input wire logic o_net_send,
    input wire logic o_s2n_clear,
    input wire logic o_n2s_clear,
    input wire logic o_drop_conn,
    input wire logic o_force_close,
    input wire logic o_send_term_type,
    input wire logic o_connected,
    input wire logic o_state_led
);
    localparam int HC_LO = 999 * MS_CYCLES - 2;
    localparam int HC_HI = 1001 * MS_CYCLES + 3;
    logic closing_q;
    logic past_open_q;
    logic past_closed_q;
    int wait_q;
    logic open_w;
    logic idle_w;

    // Connected flag lags the state; these mark cycles where the state is certain
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !o_connected) begin
            closing_q <= 1'b0;
        end else if (o_drop_conn) begin
            closing_q <= 1'b1;
        end
    end
    always_ff @(posedge i_core_clk) begin
        past_open_q <= !i_sys_rst && (i_conn_open_out || i_conn_open_in);
        past_closed_q <= !i_sys_rst && i_conn_closed;
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || o_drop_conn) begin
            wait_q <= 0;
        end else if (wait_q < HC_HI + 8) begin
            wait_q <= wait_q + 1;
        end
    end
    assign open_w = o_connected && !closing_q && !o_drop_conn && !past_closed_q;
    assign idle_w = !o_connected && !past_open_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    line_drop_a: assert property ($fell(i_line_status) && i_disconnect_policy[7] && open_w |=> o_drop_conn)
        else $error("line fall without drop");
    eot_drop_a: assert property (i_ser_valid && i_ser_byte == EOT_CHAR && i_disconnect_policy[5]
        && i_disconnect_policy[6] && open_w |=> o_drop_conn) else $error("end byte without drop");
    pw_reject_a: assert property (i_conn_open_in && !i_conn_open_out && i_disconnect_policy[4]
        && !i_password_ok && idle_w |=> o_drop_conn ##1 !o_connected) else $error("bad password accepted");
    out_open_a: assert property (i_conn_open_out && idle_w |=> o_send_term_type == $past(i_disconnect_policy[6])
        && o_s2n_clear == $past(i_buffer_clear_policy[4]) && o_n2s_clear == $past(i_buffer_clear_policy[0])
        ##1 o_connected) else $error("outgoing open pulses wrong");
    in_open_a: assert property (i_conn_open_in && !i_conn_open_out && idle_w
        && (!i_disconnect_policy[4] || i_password_ok) |=> !o_send_term_type
        && o_s2n_clear == $past(i_buffer_clear_policy[5]) && o_n2s_clear == $past(i_buffer_clear_policy[1])
        ##1 o_connected) else $error("incoming open pulses wrong");
    hard_close_a: assert property (o_force_close |-> !$past(i_disconnect_policy[3])
        && wait_q >= HC_LO && wait_q <= HC_HI) else $error("forced close at wrong time");
    led_off_a: assert property (o_connected && $past(i_disconnect_policy[0]) |-> !o_state_led)
        else $error("state indicator on while connected");
    trig_send_a: assert property (i_ser_valid && i_trigger_char_first != TRIGGER_OFF
        && i_ser_byte == i_trigger_char_first && open_w && (!i_buffer_clear_policy[7]
        || (i_packing_control[5] && !i_packing_control[4] && i_packing_control[3:2] == 2'b00))
        |=> o_net_send) else $error("trigger byte not sent at once");
endmodule

bind snp_packetizer snp_packetizer_asserts #(.MS_CYCLES(MS_CYCLES)) snp_packetizer_asserts_i (
    .i_core_clk, .i_sys_rst, .i_disconnect_policy, .i_buffer_clear_policy, .i_packing_control,
    .i_trigger_char_first, .i_ser_valid, .i_ser_byte, .i_line_status, .i_conn_open_out,
    .i_conn_open_in, .i_password_ok, .i_conn_closed, .o_net_send, .o_s2n_clear, .o_n2s_clear,
    .o_drop_conn, .o_force_close, .o_send_term_type, .o_connected, .o_state_led
);
`default_nettype wire

// ===== tb/snp_far_side.sv
// Far-side model: serial byte source and remote close acknowledge
`timescale 1ns/1ps
`default_nettype none
module snp_far_side (
    input wire logic i_core_clk,
    input wire logic i_drop,
    input wire logic i_ack_en,
    input wire logic [7:0] i_ack_dly,
    output logic o_valid,
    output logic [7:0] o_byte,
    output logic o_ack
);
    int cnt = 0;

    initial begin
        o_valid = 1'b0;
        o_byte = 8'h00;
        o_ack = 1'b0;
    end
    // Every byte counts as activity; released data shows the inverse
    task automatic burst(input logic [7:0] b[$]);
        foreach (b[i]) begin
            o_valid <= 1'b1;
            o_byte <= b[i];
            @(posedge i_core_clk);
            #1;
        end
        o_valid <= 1'b0;
        o_byte <= ~b[b.size() - 1];
    endtask
    always @(posedge i_core_clk) begin
        o_ack <= cnt == 1;
        if (i_drop && i_ack_en) begin
            cnt <= int'(i_ack_dly) + 1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/snp_packetizer_test.sv
// Self-checking bench for the serial network packetizer
`timescale 1ns/1ps
`default_nettype none
module snp_packetizer_test;
    import snp_pkg::*;
    localparam int M = 4;
    logic clk = 0, rst = 1, lin = 1, oo = 0, oi = 0, pw = 0, cc = 0, st = 0, ack_en = 1;
    logic [7:0] dp = 0, bc = 0, pc = 0, t1 = 0, t2 = 0, dly = 8'h14;
    logic [12:0] ito = 0;
    logic sv, ack, nv, ns, sc, nc, dr, fc, tt, te, con, led;
    logic [7:0] sb, nb;
    logic [8:0] exp_q[$], q[$];
    int n_fail = 0, total_checks = 0, cyc = 0, t;
    int iv[5] = '{12, 52, 250, 5000, 1};

    always #5 clk = ~clk;
    snp_packetizer #(.MS_CYCLES(M)) snp_packetizer_i (.i_core_clk(clk), .i_sys_rst(rst),
        .i_disconnect_policy(dp), .i_buffer_clear_policy(bc), .i_packing_control(pc), .i_idle_timeout(ito),
        .i_trigger_char_first(t1), .i_trigger_char_second(t2), .i_ser_valid(sv), .i_ser_byte(sb),
        .i_line_status(lin), .i_conn_open_out(oo), .i_conn_open_in(oi), .i_password_ok(pw),
        .i_conn_closed(cc), .i_close_ack(ack), .i_status_tx_req(st), .o_net_valid(nv), .o_net_byte(nb),
        .o_net_send(ns), .o_s2n_clear(sc), .o_n2s_clear(nc), .o_drop_conn(dr), .o_force_close(fc),
        .o_send_term_type(tt), .o_telnet_opts_en(te), .o_connected(con), .o_state_led(led));
    snp_far_side snp_far_side_i (.i_core_clk(clk), .i_drop(dr), .i_ack_en(ack_en), .i_ack_dly(dly),
        .o_valid(sv), .o_byte(sb), .o_ack(ack));

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_v(ref logic s, input logic v, input int lim);
        t = 0;
        while (s !== v && t < lim) begin
            tick(1);
            t++;
        end
    endtask
    function automatic logic [8:0] rb();
        return {1'b0, 8'h10 + 8'($urandom_range(0, 111))};
    endfunction
    // Expected {send, byte} notes go in order of forwarding
    task automatic send(input logic [8:0] v[$]);
        logic [7:0] b[$];
        foreach (v[i]) begin
            exp_q.push_back(v[i]);
            b.push_back(v[i][7:0]);
        end
        snp_far_side_i.burst(b);
    endtask
    task automatic conn(input logic out_dir);
        oo = out_dir;
        oi = !out_dir;
        tick(1);
        oo = 0;
        oi = 0;
        if (out_dir) chk("open pulses", {12'h0, dp[6], dp[6], bc[4], bc[0]}, {12'h0, tt, te, sc, nc});
        tick(1);
    endtask
    task automatic close();
        cc = 1;
        tick(1);
        cc = 0;
        tick(2);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc > 60000) begin
            n_fail++;
            summarize();
        end
        if (nv === 1'b1) chk("net byte", exp_q.size() ? {7'h0, exp_q.pop_front()} : 16'hffff, {7'h0, ns, nb});
    end

    initial begin
        void'($urandom(32'h2e9d));
        tick(8);
        chk("reset outputs", 16'h0001, {6'h0, nv, ns, sc, nc, dr, fc, tt, te, con, led});
        rst = 0;
        tick(2);
        // Packing settings must be ignored while the alternate mode is off
        dp = 8'h40; bc = 8'h11; pc = 8'h3c; t1 = 8'h0d;
        conn(1);
        send('{rb(), rb(), 9'h10d});
        t1 = 8'h00;
        tick(1);
        send('{rb(), 9'h00d});
        close();
        $display("done: standard packing");
        bc = 8'h80; pc = 8'h30; t1 = 8'h0d; t2 = 8'h0a; dp = 8'h00;
        conn(1);
        send('{9'h00a, 9'h00d, rb(), 9'h00d, 9'h10a});
        tick(60);
        pc = 8'h20;
        send('{rb(), 9'h10a});
        tick(60);
        for (int k = 0; k < 4; k++) begin
            pc = 8'h20 | 8'(k << 2);
            q = '{9'h00d, rb(), rb(), rb()};
            q[k == 3 ? 0 : k][8] = 1'b1;
            send(q);
            tick(60);
        end
        pc = 8'h00;
        send('{9'h00d, rb()});
        tick(1);
        chk("held send", 16'h1, {15'h0, ns});
        for (int k = 0; k < 5; k++) begin
            bc = k < 4 ? 8'h80 : 8'h00;
            pc = 8'(k & 3);
            send('{rb()});
            wait_v(ns, 1'b1, 25000);
            chk("interval", 16'h1, 16'(t >= (iv[k] - 1) * M && t <= (iv[k] + 1) * M + 3));
        end
        chk("zero timeout keeps link", 16'h1, {15'h0, con});
        close();
        $display("done: alternate packing");
        bc = 8'h44; ito = 13'h0001;
        conn(1);
        tick(600 * M);
        send('{rb()});
        wait_v(dr, 1'b1, 2000 * M);
        chk("idle drop", 16'h1, 16'(t >= 999 * M - 1 && t <= 1001 * M + 3));
        wait_v(sc, 1'b1, 100);
        chk("disconnect clears", 16'h3, {14'h0, sc, nc});
        ito = 13'h0000;
        tick(3);
        $display("done: idle timeout");
        dp = 8'h80; ack_en = 0;
        conn(1);
        lin = 0;
        wait_v(fc, 1'b1, 1002 * M + 10);
        chk("forced close", 16'h1, {15'h0, fc});
        lin = 1;
        dp = 8'h88;
        tick(3);
        conn(1);
        lin = 0;
        tick(1002 * M + 10);
        chk("no forced close", 16'h1, {15'h0, con});
        lin = 1;
        close();
        $display("done: line drop");
        dp = 8'h71; ack_en = 1; dly = 8'h01;
        bc = 8'h66;
        conn(0);
        pw = 1;
        conn(0);
        chk("indicator off", 16'h0, {15'h0, led});
        st = 1;
        tick(1);
        st = 0;
        chk("status send", 16'h1, {15'h0, ns});
        send('{9'h004});
        wait_v(con, 1'b0, 50);
        tick(1);
        chk("indicator idle", 16'h1, {15'h0, led});
        $display("done: incoming and end byte");
        tick(10);
        chk("queue empty", 16'h0, 16'(exp_q.size()));
        summarize();
    end
endmodule
`default_nettype wire
